// >>> usb_sched_pkg.sv
// package for the host controller list-scheduling control block
// assumes a 40 MHz system clock and a 32-bit word register port
package usb_sched_pkg;

   // register word addresses (byte offsets, one aligned word each)
   localparam logic [7:0] ADDR_OPERATING_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_COMMAND_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_EVENT_FLAGS       = 8'h08;
   localparam logic [7:0] ADDR_EVENT_MASK        = 8'h0c;

   // operating_control fields
   localparam int CTL_RATIO_LSB    = 0;
   localparam int CTL_PERIODIC_BIT = 2;
   localparam int CTL_ISO_BIT      = 3;
   localparam int CTL_CTRL_BIT     = 4;
   localparam int CTL_BULK_BIT     = 5;
   localparam int CTL_FSTATE_LSB   = 6;
   localparam int CTL_ROUTE_BIT    = 8;
   localparam int CTL_WAKECAP_BIT  = 9;
   localparam int CTL_WAKEEN_BIT   = 10;

   // command_and_status fields
   localparam int CMD_BULK_FILL_BIT = 2;
   localparam int CMD_OWNER_REQ_BIT = 3;
   localparam int CMD_OVR_CNT_LSB   = 16;

   // event flag / mask layout
   localparam int EVT_OVERRUN_BIT = 0;
   localparam int EVT_SOF_BIT     = 2;
   localparam int EVT_OWNER_BIT   = 30;
   localparam int EVT_WIDTH       = 32;
   localparam logic [31:0] EVT_IMPL_MASK = 32'h4000_0005;

   // reset values
   localparam logic [1:0]  RATIO_RST    = 2'h0;
   localparam logic [1:0]  OVR_CNT_RST  = 2'h0;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   // functional states of the controller
   typedef enum logic [1:0] {
      FS_RESET       = 2'b00,
      FS_RESUME      = 2'b01,
      FS_OPERATIONAL = 2'b10,
      FS_SUSPEND     = 2'b11
   } host_functional_state_e;

   // clock rate and the delay from operational entry to frame markers
   localparam int unsigned CLK_KHZ          = 40000;
   localparam int unsigned SOF_DELAY_US     = 1000;
   localparam int unsigned SOF_DELAY_CYCLES = (SOF_DELAY_US * CLK_KHZ) / 1000;
   localparam int          SOF_CNT_W        = 16;

   // control-served counter width (ratio 0..3 plus one overshoot)
   localparam int SERVED_W = 3;

endpackage : usb_sched_pkg

// >>> ratio_if.sv
// carrier between the scheduling controller and its ratio arbiter
// assumes both ends run on the same system clock
interface ratio_if;
   logic [1:0] ratio;
   logic       ctrl_served;
   logic       bulk_served;
   logic       pick_bulk;

   modport ctrl (output ratio, output ctrl_served, output bulk_served, input pick_bulk);
   modport arb  (input ratio, input ctrl_served, input bulk_served, output pick_bulk);
endinterface : ratio_if

// >>> ratio_arbiter.sv
// control/bulk service ratio arbiter
// assumes served strobes are one-cycle pulses on the system clock
module ratio_arbiter
   import usb_sched_pkg::*;
(
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // controller side
   ratio_if.arb      rif
);

   logic [SERVED_W-1:0] served_q;
   logic [SERVED_W-1:0] served_d;
   logic                pick_bulk_q;

   function automatic logic ratio_reached(input logic [SERVED_W-1:0] cnt,
                                          input logic [1:0]          ratio);
      ratio_reached = (cnt > {1'b0, ratio});
   endfunction

   // count survives frame boundaries: nothing here looks at sof
   always_comb begin
      served_d = served_q;
      if (rif.bulk_served) begin
         served_d = '0;
      end else if (rif.ctrl_served && !ratio_reached(served_q, rif.ratio)) begin
         served_d = served_q + SERVED_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         served_q <= '0;
      end else begin
         served_q <= served_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pick_bulk_q <= 1'b0;
      end else begin
         pick_bulk_q <= ratio_reached(served_d, rif.ratio);
      end
   end

   assign rif.pick_bulk = pick_bulk_q;

endmodule // ratio_arbiter

// >>> usb_list_sched_ctrl.sv
// list-scheduling controls of a full-speed usb host controller
// assumes a frame engine on the same clock giving one-cycle event pulses
//
// Added by the designer: the register offsets and the plain strobed port.
module usb_list_sched_ctrl
   import usb_sched_pkg::*;
#(
   parameter int unsigned P_SOF_DELAY_CYCLES = usb_sched_pkg::SOF_DELAY_CYCLES
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // frame engine events
   input  wire logic        i_soft_rst,
   input  wire logic        i_sof,
   input  wire logic        i_ctrl_served,
   input  wire logic        i_bulk_served,
   input  wire logic        i_bulk_head,
   input  wire logic        i_bulk_td_found,
   input  wire logic        i_sched_overrun,
   input  wire logic        i_handover_done,
   input  wire logic        i_resume_detect,
   // frame engine decisions
   output logic             o_ctrl_allow,
   output logic             o_bulk_allow,
   output logic             o_periodic_allow,
   output logic             o_iso_continue,
   output logic             o_pick_bulk,
   output logic             o_bulk_start,
   output logic             o_sof_run,
   output logic [1:0]       o_functional_state,
   // interrupt
   output logic             o_irq
);
   import usb_sched_pkg::*;

   ratio_if rif ();

   // operating_control fields
   logic [1:0]             ctrl_bulk_ratio_q;
   logic                   periodic_go_q;
   logic                   iso_go_q;
   logic                   ctrl_go_q;
   logic                   bulk_go_q;
   host_functional_state_e fstate_q;
   logic                   route_q;
   logic                   wakeup_capable_q;
   logic                   wake_en_q;
   // frame-sampled copies
   logic                   ctrl_frame_q;
   logic                   bulk_frame_q;
   logic                   periodic_frame_q;
   logic                   iso_frame_q;
   // command_and_status fields
   logic                   bulk_pending_flag_q;
   logic                   ownership_request_q;
   logic [1:0]             overrun_cnt_q;
   // events
   logic [31:0]            evt_flags_q;
   logic [31:0]            evt_mask_q;
   logic [31:0]            evt_set;
   // sof start delay
   logic [SOF_CNT_W-1:0]   sof_cnt_q;
   logic                   entering_op;
   host_functional_state_e fstate_d;
   // decode
   logic                   wr_ctl;
   logic                   wr_cmd;
   logic                   wr_mask;
   logic                   rd_flags;
   logic                   owner_req_set;

   function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] b);
      hit = strobe && (a == b);
   endfunction

   assign wr_ctl        = hit(i_wr, i_addr, ADDR_OPERATING_CONTROL);
   assign wr_cmd        = hit(i_wr, i_addr, ADDR_COMMAND_STATUS);
   assign wr_mask       = hit(i_wr, i_addr, ADDR_EVENT_MASK);
   assign rd_flags      = hit(i_rd, i_addr, ADDR_EVENT_FLAGS);
   assign owner_req_set = wr_cmd && i_wdata[CMD_OWNER_REQ_BIT];

   // software-only fields of operating_control
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ctrl_bulk_ratio_q <= RATIO_RST;
         periodic_go_q     <= 1'b0;
         iso_go_q          <= 1'b0;
         ctrl_go_q         <= 1'b0;
         bulk_go_q         <= 1'b0;
         wake_en_q         <= 1'b0;
         route_q           <= 1'b0;
      end else if (i_soft_rst) begin
         // routing tag survives a software reset
         ctrl_bulk_ratio_q <= RATIO_RST;
         periodic_go_q     <= 1'b0;
         iso_go_q          <= 1'b0;
         ctrl_go_q         <= 1'b0;
         bulk_go_q         <= 1'b0;
         wake_en_q         <= 1'b0;
      end else if (wr_ctl) begin
         ctrl_bulk_ratio_q <= i_wdata[CTL_RATIO_LSB +: 2];
         periodic_go_q     <= i_wdata[CTL_PERIODIC_BIT];
         iso_go_q          <= i_wdata[CTL_ISO_BIT];
         ctrl_go_q         <= i_wdata[CTL_CTRL_BIT];
         bulk_go_q         <= i_wdata[CTL_BULK_BIT];
         wake_en_q         <= i_wdata[CTL_WAKEEN_BIT];
         route_q           <= i_wdata[CTL_ROUTE_BIT];
      end
   end

   // wakeup_capable: cleared by hardware reset only
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wakeup_capable_q <= 1'b0;
      end else if (wr_ctl) begin
         wakeup_capable_q <= i_wdata[CTL_WAKECAP_BIT];
      end
   end

   // functional state: software writes, hardware moves on soft reset and resume
   always_comb begin
      fstate_d = fstate_q;
      if (i_soft_rst) begin
         fstate_d = FS_SUSPEND;
      end else if (wr_ctl) begin
         case (i_wdata[CTL_FSTATE_LSB +: 2])
            2'b00:   fstate_d = FS_RESET;
            2'b01:   fstate_d = FS_RESUME;
            2'b10:   fstate_d = FS_OPERATIONAL;
            2'b11:   fstate_d = FS_SUSPEND;
            default: fstate_d = FS_RESET;
         endcase
      end else if (fstate_q == FS_SUSPEND && i_resume_detect) begin
         fstate_d = FS_RESUME;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         fstate_q <= FS_RESET;
      end else begin
         fstate_q <= fstate_d;
      end
   end

   assign entering_op = (fstate_d == FS_OPERATIONAL) && (fstate_q != FS_OPERATIONAL);

   // frame markers start a fixed delay after entering operational
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sof_cnt_q <= '0;
         o_sof_run <= 1'b0;
      end else if (fstate_d != FS_OPERATIONAL) begin
         sof_cnt_q <= '0;
         o_sof_run <= 1'b0;
      end else if (entering_op) begin
         sof_cnt_q <= SOF_CNT_W'(P_SOF_DELAY_CYCLES);
         o_sof_run <= 1'b0;
      end else if (sof_cnt_q > SOF_CNT_W'(1)) begin
         sof_cnt_q <= sof_cnt_q - SOF_CNT_W'(1);
      end else if (sof_cnt_q == SOF_CNT_W'(1)) begin
         sof_cnt_q <= '0;
         o_sof_run <= 1'b1;
      end
   end

   // enables sampled at each frame start so a set acts only next frame
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         ctrl_frame_q     <= 1'b0;
         bulk_frame_q     <= 1'b0;
         periodic_frame_q <= 1'b0;
         iso_frame_q      <= 1'b0;
      end else if (i_sof) begin
         ctrl_frame_q     <= ctrl_go_q;
         bulk_frame_q     <= bulk_go_q;
         periodic_frame_q <= periodic_go_q;
         iso_frame_q      <= iso_go_q;
      end
   end

   // control, bulk and periodic check the live bit too, so a clear stops them without waiting; iso follows only the frame copy
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_ctrl_allow     <= 1'b0;
         o_bulk_allow     <= 1'b0;
         o_periodic_allow <= 1'b0;
         o_iso_continue   <= 1'b0;
      end else begin
         o_ctrl_allow     <= ctrl_go_q && ctrl_frame_q;
         o_bulk_allow     <= bulk_go_q && bulk_frame_q;
         o_periodic_allow <= periodic_go_q && periodic_frame_q;
         o_iso_continue   <= iso_frame_q;
      end
   end

   // ratio arbiter
   assign rif.ratio       = ctrl_bulk_ratio_q;
   assign rif.ctrl_served = i_ctrl_served;
   assign rif.bulk_served = i_bulk_served;

   ratio_arbiter u_ratio_arbiter (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst || i_soft_rst),
      .rif       (rif)
   );

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_pick_bulk <= 1'b0;
      end else begin
         o_pick_bulk <= rif.pick_bulk;
      end
   end

   // bulk_pending_flag: software write-to-set and descriptor found win over the start clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         bulk_pending_flag_q <= 1'b0;
      end else if ((wr_cmd && i_wdata[CMD_BULK_FILL_BIT]) || i_bulk_td_found) begin
         bulk_pending_flag_q <= 1'b1;
      end else if (i_bulk_head && bulk_pending_flag_q && o_bulk_allow) begin
         bulk_pending_flag_q <= 1'b0;
      end
   end

   // start pulse at the list head only if enabled and filled
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_bulk_start <= 1'b0;
      end else begin
         o_bulk_start <= i_bulk_head && bulk_pending_flag_q && o_bulk_allow;
      end
   end

   // ownership request: a new request wins over the handover clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         ownership_request_q <= 1'b0;
      end else if (owner_req_set) begin
         ownership_request_q <= 1'b1;
      end else if (i_handover_done) begin
         ownership_request_q <= 1'b0;
      end
   end

   // overrun counter counts regardless of the overrun flag
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         overrun_cnt_q <= OVR_CNT_RST;
      end else if (i_sched_overrun) begin
         overrun_cnt_q <= overrun_cnt_q + 2'h1;
      end
   end

   // sticky event flags, cleared by reading, set wins over read clear
   always_comb begin
      evt_set                  = WORD_ZERO;
      evt_set[EVT_OVERRUN_BIT] = i_sched_overrun;
      evt_set[EVT_SOF_BIT]     = i_sof;
      evt_set[EVT_OWNER_BIT]   = owner_req_set;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         evt_flags_q <= WORD_ZERO;
      end else if (rd_flags) begin
         evt_flags_q <= evt_set;
      end else begin
         evt_flags_q <= evt_flags_q | evt_set;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || i_soft_rst) begin
         evt_mask_q <= WORD_ZERO;
      end else if (wr_mask) begin
         evt_mask_q <= i_wdata & EVT_IMPL_MASK;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(evt_flags_q & evt_mask_q);
      end
   end

   // read data, one cycle after the strobe; zero otherwise
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_rdata <= WORD_ZERO;
      end else begin
         o_rdata <= WORD_ZERO;
         if (i_rd) begin
            case (i_addr)
               ADDR_OPERATING_CONTROL: begin
                  o_rdata[CTL_RATIO_LSB +: 2]  <= ctrl_bulk_ratio_q;
                  o_rdata[CTL_PERIODIC_BIT]    <= periodic_go_q;
                  o_rdata[CTL_ISO_BIT]         <= iso_go_q;
                  o_rdata[CTL_CTRL_BIT]        <= ctrl_go_q;
                  o_rdata[CTL_BULK_BIT]        <= bulk_go_q;
                  o_rdata[CTL_FSTATE_LSB +: 2] <= fstate_q;
                  o_rdata[CTL_ROUTE_BIT]       <= route_q;
                  o_rdata[CTL_WAKECAP_BIT]     <= wakeup_capable_q;
                  o_rdata[CTL_WAKEEN_BIT]      <= wake_en_q;
               end
               ADDR_COMMAND_STATUS: begin
                  o_rdata[CMD_BULK_FILL_BIT]    <= bulk_pending_flag_q;
                  o_rdata[CMD_OWNER_REQ_BIT]    <= ownership_request_q;
                  o_rdata[CMD_OVR_CNT_LSB +: 2] <= overrun_cnt_q;
               end
               ADDR_EVENT_FLAGS: o_rdata <= evt_flags_q;
               ADDR_EVENT_MASK:  o_rdata <= evt_mask_q;
               default:          o_rdata <= WORD_ZERO;
            endcase
         end
      end
   end

   assign o_functional_state = fstate_q;

endmodule // usb_list_sched_ctrl

// >>> usb_list_sched_ctrl_assertions.sv
// concurrent checks on the list-scheduling control block's ports
// assumes one system clock and synchronous active-high reset
module usb_list_sched_ctrl_checker
   import usb_sched_pkg::*;
#(
   parameter int unsigned P_SOF_DELAY_CYCLES = 20
) (
   // clock and reset
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   // register port
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   // frame engine events
   input wire logic        i_soft_rst,
   input wire logic        i_sof,
   input wire logic        i_ctrl_served,
   input wire logic        i_bulk_served,
   input wire logic        i_bulk_head,
   input wire logic        i_bulk_td_found,
   input wire logic        i_sched_overrun,
   input wire logic        i_handover_done,
   input wire logic        i_resume_detect,
   // decisions and interrupt
   input wire logic        o_ctrl_allow,
   input wire logic        o_bulk_allow,
   input wire logic        o_periodic_allow,
   input wire logic        o_iso_continue,
   input wire logic        o_pick_bulk,
   input wire logic        o_bulk_start,
   input wire logic        o_sof_run,
   input wire logic [1:0]  o_functional_state,
   input wire logic        o_irq
);
   int unsigned op_cnt_q;
   logic        ctl_wr;

   // saturates so a long operational stay cannot wrap the count
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || o_functional_state != FS_OPERATIONAL) begin
         op_cnt_q <= 0;
      end else if (op_cnt_q < P_SOF_DELAY_CYCLES + 4) begin
         op_cnt_q <= op_cnt_q + 1;
      end
   end
   assign ctl_wr = i_wr && i_addr == ADDR_OPERATING_CONTROL;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // cause lands in an enable or frame copy first, the decision register one edge later
   ctrl_allow_a: assert property ($changed(o_ctrl_allow) |-> $past(i_sof || ctl_wr || i_soft_rst, 2))
      else $error("control allow moved without frame start or write");
   periodic_allow_a: assert property ($changed(o_periodic_allow) |-> $past(i_sof || ctl_wr || i_soft_rst, 2))
      else $error("periodic allow moved without frame start or write");
   bulk_allow_a: assert property ($changed(o_bulk_allow) |-> $past(i_sof || ctl_wr || i_soft_rst, 2))
      else $error("bulk allow moved without frame start or write");
   iso_frame_a: assert property ($changed(o_iso_continue) |-> $past(i_sof || i_soft_rst, 2))
      else $error("iso decision changed inside a frame");
   // served strobes pass the arbiter flop and the output flop; a ratio write has one more
   pick_cause_a: assert property ($changed(o_pick_bulk) |->
      $past(i_ctrl_served || i_bulk_served || i_soft_rst, 2) || $past(i_wr, 3))
      else $error("bulk pick moved without a served event");
   bulk_start_a: assert property (o_bulk_start |-> $past(i_bulk_head && o_bulk_allow))
      else $error("bulk start without head event or allow");
   sof_delay_a: assert property ($rose(o_sof_run) |-> op_cnt_q + 2 >= P_SOF_DELAY_CYCLES && op_cnt_q <= P_SOF_DELAY_CYCLES + 1)
      else $error("frame markers began at the wrong delay");
   fstate_src_a: assert property ($changed(o_functional_state) |-> $past(ctl_wr || i_soft_rst || i_resume_detect))
      else $error("functional state changed without a cause");
   rdata_idle_a: assert property ($past(!i_rd || i_addr > ADDR_EVENT_MASK) |-> o_rdata == WORD_ZERO)
      else $error("read data not zero outside a mapped read");
   irq_cause_a: assert property ($rose(o_irq) |-> $past(i_sched_overrun || i_sof || i_wr, 2))
      else $error("interrupt rose without an event or mask write");

   cover property (o_bulk_start);
   cover property ($rose(o_pick_bulk));
   cover property ($rose(o_sof_run));
   cover property ($rose(o_irq));
endmodule // usb_list_sched_ctrl_checker

bind usb_list_sched_ctrl usb_list_sched_ctrl_checker #(.P_SOF_DELAY_CYCLES(P_SOF_DELAY_CYCLES)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_soft_rst(i_soft_rst), .i_sof(i_sof), .i_ctrl_served(i_ctrl_served),
   .i_bulk_served(i_bulk_served), .i_bulk_head(i_bulk_head), .i_bulk_td_found(i_bulk_td_found),
   .i_sched_overrun(i_sched_overrun), .i_handover_done(i_handover_done), .i_resume_detect(i_resume_detect),
   .o_ctrl_allow(o_ctrl_allow), .o_bulk_allow(o_bulk_allow), .o_periodic_allow(o_periodic_allow),
   .o_iso_continue(o_iso_continue), .o_pick_bulk(o_pick_bulk), .o_bulk_start(o_bulk_start),
   .o_sof_run(o_sof_run), .o_functional_state(o_functional_state), .o_irq(o_irq)
);

// >>> usb_list_sched_ctrl_test.sv
// self-checking bench for the list-scheduling control block
// assumes the bench plays both host driver and frame engine
module usb_list_sched_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import usb_sched_pkg::*;

   // short delay so the operational wait stays brief
   localparam int unsigned SOF_DLY = 20;
   localparam int E_SRST = 0, E_SOF = 1, E_CSRV = 2, E_BSRV = 3, E_HEAD = 4;
   localparam int E_FOUND = 5, E_OVR = 6, E_HOVER = 7, E_RESUME = 8;

   logic        clk_sys, rst, wr, rd;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [8:0]  ev;
   logic        ctrl_allow, bulk_allow, periodic_allow, iso_continue;
   logic        pick_bulk, bulk_start, sof_run, irq;
   logic [1:0]  fstate;
   logic [5:0]  allow_v;
   int          go_bits [3] = '{2, 4, 5};
   int          miscompares = 0;
   int          cmp_count = 0;

   // allow outputs laid out at their enable bit positions
   assign allow_v = {bulk_allow, ctrl_allow, 1'b0, periodic_allow, 2'b00};

   usb_list_sched_ctrl #(.P_SOF_DELAY_CYCLES(SOF_DLY)) u_usb_list_sched_ctrl (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_soft_rst(ev[E_SRST]), .i_sof(ev[E_SOF]), .i_ctrl_served(ev[E_CSRV]),
      .i_bulk_served(ev[E_BSRV]), .i_bulk_head(ev[E_HEAD]), .i_bulk_td_found(ev[E_FOUND]),
      .i_sched_overrun(ev[E_OVR]), .i_handover_done(ev[E_HOVER]), .i_resume_detect(ev[E_RESUME]),
      .o_ctrl_allow(ctrl_allow), .o_bulk_allow(bulk_allow), .o_periodic_allow(periodic_allow),
      .o_iso_continue(iso_continue), .o_pick_bulk(pick_bulk), .o_bulk_start(bulk_start),
      .o_sof_run(sof_run), .o_functional_state(fstate), .o_irq(irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask

   task automatic pulse(input int b, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         ev[b] <= 1'b1;
         @(posedge clk_sys);
         ev[b] <= 1'b0;
      end
      #1;
   endtask

   // decisions pass two flops after their cause, so wait an extra edge before looking
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      ev = 9'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(ADDR_OPERATING_CONTROL, 32'hffff_ffff, WORD_ZERO);
      rd_chk(ADDR_COMMAND_STATUS, 32'hffff_ffff, WORD_ZERO);
      wr_reg(8'h10, 32'hffff_ffff);
      rd_chk(8'h10, 32'hffff_ffff, WORD_ZERO);
      wr_reg(ADDR_EVENT_FLAGS, 32'hffff_ffff);
      rd_chk(ADDR_EVENT_FLAGS, 32'hffff_ffff, WORD_ZERO);
      // every ratio code; a frame edge in mid-count must not lose it
      for (int r = 0; r < 4; r++) begin
         wr_reg(ADDR_OPERATING_CONTROL, 32'h33c | 32'(r));
         rd_chk(ADDR_OPERATING_CONTROL, 32'h3, 32'(r));
         pulse(E_BSRV, 1);
         pulse(E_CSRV, r);
         pulse(E_SOF, 1);
         chk(32'(pick_bulk), 32'h0);
         pulse(E_CSRV, 1);
         idle(1);
         chk(32'(pick_bulk), 32'h1);
         pulse(E_BSRV, 1);
         idle(1);
         chk(32'(pick_bulk), 32'h0);
      end
      wr_reg(ADDR_OPERATING_CONTROL, 32'h33f);
      pulse(E_SOF, 1);
      chk(32'({bulk_allow, ctrl_allow, periodic_allow, iso_continue}), 32'hf);
      rd_chk(ADDR_OPERATING_CONTROL, 32'h7ff, 32'h33f);
      for (int i = 0; i < 3; i++) begin
         wr_reg(ADDR_OPERATING_CONTROL, 32'h33f & ~(32'h1 << go_bits[i]));
         pulse(E_SOF, 1);
         chk(32'(allow_v[go_bits[i]]), 32'h0);
         wr_reg(ADDR_OPERATING_CONTROL, 32'h33f);
         chk(32'(allow_v[go_bits[i]]), 32'h0);
         pulse(E_SOF, 1);
         idle(1);
         chk(32'(allow_v[go_bits[i]]), 32'h1);
      end
      wr_reg(ADDR_OPERATING_CONTROL, 32'h337);
      chk(32'(iso_continue), 32'h1);
      pulse(E_SOF, 1);
      idle(1);
      chk(32'(iso_continue), 32'h0);
      wr_reg(ADDR_OPERATING_CONTROL, 32'h33f);
      chk(32'(iso_continue), 32'h0);
      pulse(E_SOF, 1);
      idle(1);
      chk(32'(iso_continue), 32'h1);
      // bulk list head with the pending flag clear, set, refilled, drained
      pulse(E_HEAD, 1);
      chk(32'(bulk_start), 32'h0);
      wr_reg(ADDR_COMMAND_STATUS, 32'h4);
      pulse(E_HEAD, 1);
      chk(32'(bulk_start), 32'h1);
      rd_chk(ADDR_COMMAND_STATUS, 32'h4, 32'h0);
      pulse(E_FOUND, 1);
      rd_chk(ADDR_COMMAND_STATUS, 32'h4, 32'h4);
      pulse(E_HEAD, 1);
      chk(32'(bulk_start), 32'h1);
      pulse(E_HEAD, 1);
      chk(32'(bulk_start), 32'h0);
      rd_chk(ADDR_COMMAND_STATUS, 32'h4, 32'h0);
      // overrun count wraps while its flag is already set
      rd_chk(ADDR_EVENT_FLAGS, EVT_IMPL_MASK, 32'h4);
      wr_reg(ADDR_EVENT_MASK, 32'h1);
      pulse(E_OVR, 5);
      rd_chk(ADDR_COMMAND_STATUS, 32'h0003_0000, 32'h0001_0000);
      chk(32'(irq), 32'h1);
      wr_reg(ADDR_COMMAND_STATUS, 32'h0003_0000);
      rd_chk(ADDR_COMMAND_STATUS, 32'h0003_0000, 32'h0001_0000);
      wr_reg(ADDR_EVENT_MASK, 32'h0);
      rd_chk(ADDR_EVENT_MASK, 32'hffff_ffff, 32'h0);
      chk(32'(irq), 32'h0);
      wr_reg(ADDR_EVENT_MASK, 32'h1);
      rd_chk(ADDR_EVENT_MASK, 32'hffff_ffff, 32'h1);
      chk(32'(irq), 32'h1);
      rd_chk(ADDR_EVENT_FLAGS, EVT_IMPL_MASK, 32'h1);
      rd_chk(ADDR_EVENT_FLAGS, EVT_IMPL_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      // ownership request and handover
      wr_reg(ADDR_COMMAND_STATUS, 32'h8);
      rd_chk(ADDR_COMMAND_STATUS, 32'h8, 32'h8);
      rd_chk(ADDR_EVENT_FLAGS, 32'h4000_0000, 32'h4000_0000);
      pulse(E_HOVER, 1);
      rd_chk(ADDR_COMMAND_STATUS, 32'h8, 32'h0);
      // operational entry, delayed frame markers, software reset, resume
      wr_reg(ADDR_OPERATING_CONTROL, 32'h3bf);
      chk(32'(fstate), 32'h2);
      repeat (SOF_DLY - 3) @(posedge clk_sys);
      #1;
      chk(32'(sof_run), 32'h0);
      repeat (6) @(posedge clk_sys);
      #1;
      chk(32'(sof_run), 32'h1);
      pulse(E_SRST, 1);
      chk(32'(fstate), 32'h3);
      rd_chk(ADDR_OPERATING_CONTROL, 32'h7ff, 32'h3c0);
      pulse(E_RESUME, 1);
      chk(32'(fstate), 32'h1);
      final_report();
   end
endmodule // usb_list_sched_ctrl_test
